// ---- dsm_signal_modulator.sv ----
// Purpose: data signal modulator with avalon-mm register slave
// Assumes: single 100 MHz clock, synchronous active-high reset
// Notes: keying and carrier inputs are pins or foreign-clock outputs, so all are resynchronised
`timescale 1ns/1ps
`default_nettype none
`include "dsm_cfg.svh"

// Contract
// - reset disables the modulator and returns every register to its default.
// - control bit 6 gates the result onto the output pin, low when clear.
// - control bit 4 inverts the final output.
// - control bit 3 reads the present output; may be stale for fast signals.
// - source bits 3-0 pick the keying input; codes 1110, 1101 pick PWM units.
// - carrier-high bit 6 inverts the carrier-high source.
// - carrier-low bit 6 inverts the carrier-low source.
// - carrier-high bit 5 holds switch to low carrier until high carrier falls.
// - carrier-low bit 5 holds switch to high carrier until low carrier falls.
// - without wait bit the switch follows the keying change at once.
// - unsynchronised switching may leave short pulses or spurs.
// - carrier select decodes ground, pins, reference clocks, PWM units, system clock.
// - carrier-low select decodes as carrier-high, 0000 is ground.
// - carrier bit 7 detaches the selected carrier peripheral from its pin.
// - unimplemented register bits read as zero.
// - disable forces carriers to ground and keying to software bit, keeps registers.
// - software keying bit is the keying signal when selected.
// - source detach bit stops the keying peripheral driving its own pin.
// - clearing slew bit removes output slew limiting; resets to limited.
module dsm_signal_modulator (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // keying sources, index = selector code; code 0 is the software bit
  input wire logic [15:0] keying_sources,
  // carrier sources, index = selector code; 0 ground, 14 system clock
  input wire logic [15:0] carrier_sources,
  // modulated pin
  output logic mod_pin_out,
  output logic mod_pin_oe,
  output logic slew_limit,
  // pin detach requests toward peripherals, bit index = selector code; carrier vector ORs the high and low requests
  output logic [15:0] keying_pin_detach,
  output logic [15:0] carrier_pin_detach
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dsm_pkg::dsm_reg_state_type r_q;
  dsm_pkg::dsm_reg_state_type r_d;
  logic [15:0] key_s1_q;
  logic [15:0] key_s2_q;
  logic [15:0] key_s3_q;
  logic [15:0] key_q;
  logic [15:0] car_s1_q;
  logic [15:0] car_s2_q;
  logic [15:0] car_s3_q;
  logic [15:0] car_q;
  dsm_pkg::dsm_mix_in_type mix_in;
  logic mix_out;
  logic enabled;
  logic [3:0] key_sel;
  logic [3:0] high_sel;
  logic [3:0] low_sel;
  logic access;
  logic [7:0] be_mask;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-lane merge of the low byte; upper lanes hold no bits
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic [7:0] wmask, input logic lane);
    merge_byte = lane ? ((new_v & wmask) | (old_v & ~wmask)) : old_v;
  endfunction

  // carrier selection with polarity applied
  function automatic logic pick_carrier(input logic [15:0] srcs, input logic [3:0] sel,
                                        input logic inv);
    logic v;
    v = (sel == `DSM_SEL_GROUND) ? 1'b0 : srcs[sel];
    pick_carrier = v ^ inv;
  endfunction

  // one-hot detach request for a selected peripheral
  function automatic logic [15:0] detach_vec(input logic [3:0] sel, input logic on);
    detach_vec = on ? (16'h0001 << sel) : 16'h0000;
  endfunction

  // ----------------------------------------------------------------
  // input resynchronisers: three stages, accept once stages 2 and 3 agree
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      key_s1_q <= 16'h0000;
      key_s2_q <= 16'h0000;
      key_s3_q <= 16'h0000;
      key_q <= 16'h0000;
      car_s1_q <= 16'h0000;
      car_s2_q <= 16'h0000;
      car_s3_q <= 16'h0000;
      car_q <= 16'h0000;
    end else begin
      key_s1_q <= keying_sources;
      key_s2_q <= key_s1_q;
      key_s3_q <= key_s2_q;
      key_q <= (key_s2_q & key_s3_q) | (key_q & (key_s2_q ^ key_s3_q));
      car_s1_q <= carrier_sources;
      car_s2_q <= car_s1_q;
      car_s3_q <= car_s2_q;
      car_q <= (car_s2_q & car_s3_q) | (car_q & (car_s2_q ^ car_s3_q));
    end
  end

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  // disable forces ground carriers and software keying, registers untouched
  assign enabled = r_q.control[`DSM_CTL_ENABLE];
  assign key_sel = enabled ? r_q.source[3:0] : `DSM_SEL_SWBIT;
  assign high_sel = enabled ? r_q.car_high.select : `DSM_SEL_GROUND;
  assign low_sel = enabled ? r_q.car_low.select : `DSM_SEL_GROUND;

  always_comb begin
    mix_in = '0;
    // software bit stands at code 0; other codes index the peripheral lines
    mix_in.key = (key_sel == `DSM_SEL_SWBIT) ? r_q.control[`DSM_CTL_SW_BIT] : key_q[key_sel];
    // system clock at code 14 is only representable as a constant high at this rate
    mix_in.high_carrier = (high_sel == `DSM_SEL_SYSCLK) ? ~r_q.car_high.invert
                          : pick_carrier(car_q, high_sel, r_q.car_high.invert);
    mix_in.low_carrier = (low_sel == `DSM_SEL_SYSCLK) ? ~r_q.car_low.invert
                         : pick_carrier(car_q, low_sel, r_q.car_low.invert);
    mix_in.high_wait = r_q.car_high.edge_wait;
    mix_in.low_wait = r_q.car_low.edge_wait;
    mix_in.out_invert = r_q.control[`DSM_CTL_OUT_INV];
    mix_in.pin_oe = r_q.control[`DSM_CTL_PIN_OE];
  end

  dsm_mixer u_mixer (
    .clk(clk),
    .reset(reset),
    .mix_in(mix_in),
    .mod_out(mix_out),
    .active_high()
  );

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  // every access waits one cycle, so read data come from a flop
  assign access = (avs_read | avs_write) & ~r_q.waitreq_done;
  assign be_mask = {8{avs_byteenable[0]}};

  always_comb begin
    r_d = r_q;
    r_d.waitreq_done = access;
    // status bit caught through two flops before reading
    r_d.status_sync = {r_q.status_sync[1:0], mix_out};
    if (access && avs_write) begin
      unique case (avs_address)
        `DSM_ADDR_CONTROL: r_d.control = merge_byte(r_q.control, avs_writedata[7:0],
                                                   `DSM_CTL_WMASK, be_mask[0]);
        `DSM_ADDR_SOURCE: r_d.source = merge_byte(r_q.source, avs_writedata[7:0],
                                                 `DSM_SRC_WMASK, be_mask[0]);
        `DSM_ADDR_CAR_HIGH: r_d.car_high = merge_byte(r_q.car_high, avs_writedata[7:0],
                                                     `DSM_CAR_WMASK, be_mask[0]);
        `DSM_ADDR_CAR_LOW: r_d.car_low = merge_byte(r_q.car_low, avs_writedata[7:0],
                                                   `DSM_CAR_WMASK, be_mask[0]);
        default: r_d.control = r_q.control;
      endcase
    end
    r_d.readdata = 32'h0000_0000;
    if (access && avs_read) begin
      // unimplemented bits masked to zero; unmapped reads return zero
      unique case (avs_address)
        `DSM_ADDR_CONTROL: begin
          r_d.readdata[7:0] = r_q.control & `DSM_CTL_WMASK;
          r_d.readdata[`DSM_CTL_STATUS] = r_q.status_sync[1];
        end
        `DSM_ADDR_SOURCE: r_d.readdata[7:0] = r_q.source & `DSM_SRC_WMASK;
        `DSM_ADDR_CAR_HIGH: r_d.readdata[7:0] = r_q.car_high & `DSM_CAR_WMASK;
        `DSM_ADDR_CAR_LOW: r_d.readdata[7:0] = r_q.car_low & `DSM_CAR_WMASK;
        default: r_d.readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      // every register back to default, modulator off
      r_q <= '0;
      r_q.control <= `DSM_CTL_RESET;
      r_q.source <= `DSM_SRC_RESET;
      r_q.car_high <= `DSM_CAR_RESET;
      r_q.car_low <= `DSM_CAR_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~r_q.waitreq_done;
  assign avs_readdata = r_q.readdata;

  // ----------------------------------------------------------------
  // pin side
  // ----------------------------------------------------------------
  // output stays low while gated; software must configure first, nothing enforced
  assign mod_pin_out = mix_out;
  assign mod_pin_oe = r_q.control[`DSM_CTL_PIN_OE];
  assign slew_limit = r_q.control[`DSM_CTL_SLEW];
  assign keying_pin_detach = detach_vec(r_q.source[3:0], r_q.source[`DSM_SRC_DETACH]);
  assign carrier_pin_detach = detach_vec(r_q.car_high.select, r_q.car_high.pin_detach)
                              | detach_vec(r_q.car_low.select, r_q.car_low.pin_detach);

endmodule

`default_nettype wire

// ---- dsm_cfg.svh ----
// Purpose: offsets, field positions, reset values and selector codes of the signal modulator
// Assumes: 32-bit avalon-mm word registers, 100 MHz clk
// Notes: included by its bare name
`ifndef DSM_CFG_SVH
`define DSM_CFG_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define DSM_ADDR_CONTROL 4'h0
`define DSM_ADDR_SOURCE 4'h4
`define DSM_ADDR_CAR_HIGH 4'h8
`define DSM_ADDR_CAR_LOW 4'hc

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define DSM_CTL_ENABLE 7
`define DSM_CTL_PIN_OE 6
`define DSM_CTL_SLEW 5
`define DSM_CTL_OUT_INV 4
`define DSM_CTL_STATUS 3
`define DSM_CTL_SW_BIT 0
`define DSM_CTL_WMASK 8'hf1

// ----------------------------------------------------------------
// source and carrier register fields
// ----------------------------------------------------------------
`define DSM_SRC_DETACH 7
`define DSM_SRC_WMASK 8'h8f
`define DSM_CAR_DETACH 7
`define DSM_CAR_INV 6
`define DSM_CAR_WAIT 5
`define DSM_CAR_WMASK 8'hef

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DSM_CTL_RESET 8'h20
`define DSM_SRC_RESET 8'h00
`define DSM_CAR_RESET 8'h00

// ----------------------------------------------------------------
// selector codes
// ----------------------------------------------------------------
`define DSM_SEL_GROUND 4'h0
`define DSM_SEL_SWBIT 4'h0
`define DSM_SEL_SYSCLK 4'he

`endif

// ---- dsm_pkg.sv ----
// Purpose: types shared by the signal modulator files
// Assumes: nothing
// Notes: constants live in dsm_cfg.svh
package dsm_pkg;

  // one carrier control register, split into its fields
  typedef struct packed {
    logic pin_detach;
    logic invert;
    logic edge_wait;
    logic unused;
    logic [3:0] select;
  } dsm_carrier_type;

  // selection of the mixer's active carrier
  typedef enum logic {
    DSM_ACT_LOW,
    DSM_ACT_HIGH
  } dsm_active_type;

  // settings the mixer needs, as one bundle
  typedef struct packed {
    logic key;
    logic high_carrier;
    logic low_carrier;
    logic high_wait;
    logic low_wait;
    logic out_invert;
    logic pin_oe;
  } dsm_mix_in_type;

  // mixer state
  typedef struct packed {
    dsm_active_type active;
    logic high_prev;
    logic low_prev;
    logic out;
  } dsm_mix_state_type;

  // register-side state
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] source;
    dsm_carrier_type car_high;
    dsm_carrier_type car_low;
    logic waitreq_done;
    logic [31:0] readdata;
    logic [2:0] status_sync;
  } dsm_reg_state_type;

endpackage

// ---- dsm_mixer.sv ----
// Purpose: carrier switching with optional falling-edge wait, polarity and output gating
// Assumes: carriers are already sampled into the clk domain
// Notes: one cycle from key change to output when no wait is armed
`timescale 1ns/1ps
`default_nettype none

module dsm_mixer (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // settings and live signals
  input wire dsm_pkg::dsm_mix_in_type mix_in,
  // result
  output logic mod_out,
  output logic active_high
);

  dsm_pkg::dsm_mix_state_type s_q;
  dsm_pkg::dsm_mix_state_type s_d;
  logic high_fall;
  logic low_fall;
  logic carrier;

  always_comb begin
    s_d = s_q;
    high_fall = s_q.high_prev & ~mix_in.high_carrier;
    low_fall = s_q.low_prev & ~mix_in.low_carrier;
    s_d.high_prev = mix_in.high_carrier;
    s_d.low_prev = mix_in.low_carrier;
    unique case (s_q.active)
      dsm_pkg::DSM_ACT_HIGH: begin
        // with wait armed, hold high carrier until its falling edge
        if (!mix_in.key && (!mix_in.high_wait || high_fall)) begin
          s_d.active = dsm_pkg::DSM_ACT_LOW;
        end
      end
      dsm_pkg::DSM_ACT_LOW: begin
        if (mix_in.key && (!mix_in.low_wait || low_fall)) begin
          s_d.active = dsm_pkg::DSM_ACT_HIGH;
        end
      end
    endcase
    // unsynchronised switching may clip carrier pulses; accepted
    carrier = (s_d.active == dsm_pkg::DSM_ACT_HIGH) ? mix_in.high_carrier : mix_in.low_carrier;
    // invert then gate; gated pin sits low
    s_d.out = mix_in.pin_oe & (carrier ^ mix_in.out_invert);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign mod_out = s_q.out;
  assign active_high = (s_q.active == dsm_pkg::DSM_ACT_HIGH);

endmodule

`default_nettype wire

// ---- dsm_src_model.sv ----
// Purpose: peripheral and pin outputs that feed the modulator's source inputs
// Assumes: the bench sets the wanted levels
// Notes: one flop stage, like a peripheral's own output register
`timescale 1ns/1ps
`default_nettype none
module dsm_src_model (
  // clock
  input wire logic clk,
  // levels asked for by the bench
  input wire logic [15:0] key_lvl,
  input wire logic [15:0] car_lvl,
  // source outputs
  output logic [15:0] keying_sources,
  output logic [15:0] carrier_sources
);
  logic tog = 1'b0;
  // unused keying slot 0 and carrier slot 14 keep moving so a stale value never passes for a driven one
  always_ff @(posedge clk) begin
    tog <= ~tog;
    keying_sources <= {key_lvl[15:1], tog};
    carrier_sources <= {car_lvl[15], tog, car_lvl[13:1], 1'b0};
  end
endmodule
`default_nettype wire

// ---- dsm_checker.sv ----
// Purpose: port properties of the signal modulator
// Assumes: bound to dsm_signal_modulator, single clock
// Notes: exact pin values are left to the bench
`timescale 1ns/1ps
`default_nettype none
module dsm_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // pins
  input wire logic mod_pin_out,
  input wire logic mod_pin_oe,
  input wire logic slew_limit,
  input wire logic [15:0] keying_pin_detach,
  input wire logic [15:0] carrier_pin_detach
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  property p_rst;
    $past(reset) |-> slew_limit && !mod_pin_oe && !mod_pin_out && keying_pin_detach == 16'h0
      && carrier_pin_detach == 16'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("pins not at reset values");
  property p_wait;
    s_req |=> s_ans;
  endproperty
  a_wait: assert property (p_wait) else $error("no answer one cycle after request");
  property p_ctl;
    s_ans ##0 (avs_write && avs_address == 4'h0 && avs_byteenable[0])
      |-> mod_pin_oe == avs_writedata[6] && slew_limit == avs_writedata[5];
  endproperty
  a_ctl: assert property (p_ctl) else $error("pin enable or slew not as written");
  // output flop lags the gate by one stage; three cycles leave one to spare
  property p_gate;
    !mod_pin_oe [*3] |-> !mod_pin_out;
  endproperty
  a_gate: assert property (p_gate) else $error("pin driven while gated");
  property p_upper;
    s_ans ##0 avs_read |-> avs_readdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read lanes not zero");
  property p_unimpl;
    s_ans ##0 avs_read |-> (avs_address != 4'h0 || avs_readdata[2:1] == 2'h0)
      && (avs_address != 4'h4 || avs_readdata[6:4] == 3'h0)
      && (!(avs_address inside {4'h8, 4'hc}) || !avs_readdata[4]);
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit reads one");
  property p_unmapped;
    s_ans ##0 (avs_read && !(avs_address inside {4'h0, 4'h4, 4'h8, 4'hc}))
      |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_detach;
    s_ans ##0 (avs_write && avs_address == 4'h4 && avs_byteenable[0]) |=> keying_pin_detach
      == ($past(avs_writedata[7]) ? 16'h1 << $past(avs_writedata[3:0]) : 16'h0);
  endproperty
  a_detach: assert property (p_detach) else $error("keying detach not as written");
endmodule
`default_nettype wire

// ---- test_data_signal_modulator.sv ----
// Purpose: self-checking bench for the signal modulator
// Assumes: answer within 20 cycles, source change reaches the pin within 8 cycles
// Notes: static source levels; edge waits are provoked by dropping a held carrier
`timescale 1ns/1ps
`default_nettype none
module test_data_signal_modulator;
  logic clk, reset, avs_read, avs_write, avs_waitrequest, e;
  logic mod_pin_out, mod_pin_oe, slew_limit;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [15:0] key_lvl, car_lvl, keying_sources, carrier_sources;
  logic [15:0] keying_pin_detach, carrier_pin_detach;
  int error_cnt;
  int comparisons;
  dsm_signal_modulator dut (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .keying_sources, .carrier_sources,
    .mod_pin_out, .mod_pin_oe, .slew_limit, .keying_pin_detach, .carrier_pin_detach);
  dsm_src_model src (.clk, .key_lvl, .car_lvl, .keying_sources, .carrier_sources);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask
  // waitrequest and read data are taken at the rising edge, before that edge's updates land
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      $display("BAD waitrequest expected 0 seen %b", avs_waitrequest);
      error_cnt++;
      stop_test;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input string name, input logic [3:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h0);
    chk(name, {24'h0, x}, q);
  endtask
  task automatic pin(input logic x);
    repeat (8) @(posedge clk);
    #1;
    chk("mod_pin_out", {31'h0, x}, {31'h0, mod_pin_out});
    // return on a rising edge so the next stimulus lands there
    @(posedge clk);
  endtask
  initial begin
    reset = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    key_lvl = 16'h0;
    car_lvl = 16'h0;
    error_cnt = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd("control", 4'h0, 8'h20);
    rd("source", 4'h4, 8'h00);
    rd("car_high", 4'h8, 8'h00);
    rd("car_low", 4'hc, 8'h00);
    $display("test reset done");
    wr(4'h0, 8'h86);
    rd("control", 4'h0, 8'h80);
    chk("slew_limit", 32'h0, {31'h0, slew_limit});
    wr(4'h4, 8'hff);
    rd("source", 4'h4, 8'h8f);
    wr(4'h8, 8'hff);
    wr(4'hc, 8'hff);
    rd("car_high", 4'h8, 8'hef);
    rd("car_low", 4'hc, 8'hef);
    chk("keying_pin_detach", 32'h8000, {16'h0, keying_pin_detach});
    chk("carrier_pin_detach", 32'h8000, {16'h0, carrier_pin_detach});
    wr(4'h2, 8'hff);
    rd("unmapped", 4'h2, 8'h00);
    avs_byteenable <= 4'h0;
    wr(4'h4, 8'h00);
    avs_byteenable <= 4'hf;
    rd("source", 4'h4, 8'h8f);
    $display("test registers done");
    for (int i = 0; i < 64; i++) begin
      wr(4'h8, {1'b0, i[3], 6'h01});
      wr(4'hc, {1'b0, !i[3], 6'h02});
      wr(4'h4, {7'h0, !i[5]});
      key_lvl <= {14'h0, i[0] ^ i[5], 1'b0};
      car_lvl <= {13'h0, i[2], i[1], 1'b0};
      wr(4'h0, {3'h7, i[4], 3'h0, i[0] ^ !i[5]});
      e = (i[0] ? i[1] ^ i[3] : i[2] ^ !i[3]) ^ i[4];
      pin(e);
      bus(1'b0, 4'h0, 8'h0);
      chk("status", {31'h0, e}, {31'h0, q[3]});
    end
    $display("test mixer done");
    wr(4'h8, 8'h01);
    wr(4'hc, 8'h02);
    wr(4'h4, 8'h01);
    key_lvl <= 16'h0;
    car_lvl <= 16'h0006;
    wr(4'h0, 8'hc0);
    pin(1'b1);
    wr(4'h0, 8'h40);
    pin(1'b0);
    rd("car_low", 4'hc, 8'h02);
    wr(4'h0, 8'h50);
    pin(1'b1);
    wr(4'h0, 8'hc0);
    pin(1'b1);
    wr(4'h0, 8'h80);
    pin(1'b0);
    $display("test enable done");
    for (int j = 0; j < 2; j++) begin
      car_lvl <= j ? 16'h0004 : 16'h0002;
      key_lvl <= j ? 16'h0 : 16'h0002;
      wr(4'h8, {2'h0, j == 0, 5'h01});
      wr(4'hc, {2'h0, j == 1, 5'h02});
      wr(4'h0, 8'hc0);
      pin(1'b1);
      key_lvl <= j ? 16'h0002 : 16'h0;
      pin(1'b1);
      car_lvl <= 16'h0;
      pin(1'b0);
    end
    $display("test edge wait done");
    for (int j = 0; j < 64; j++) begin
      car_lvl <= j[4] ? 16'haaaa : 16'h5555;
      key_lvl <= j[5] ? 16'h0 : 16'h0002;
      wr(j[5] ? 4'hc : 4'h8, {j[4], 3'h0, j[3:0]});
      wr(j[5] ? 4'h8 : 4'hc, 8'h00);
      e = (j[3:0] == 0) ? 1'b0 : (j[3:0] == 14) ? 1'b1 : car_lvl[j[3:0]];
      pin(e);
      chk("carrier_pin_detach", j[4] ? 32'h1 << j[3:0] : 32'h0, {16'h0, carrier_pin_detach});
    end
    wr(4'h8, 8'h0e);
    wr(4'hc, 8'h00);
    for (int k = 1; k < 32; k++) begin
      if (k[3:0] == 0) continue;
      key_lvl <= k[4] ? 16'haaaa : 16'h5555;
      wr(4'h4, {k[4], 3'h0, k[3:0]});
      pin(key_lvl[k[3:0]]);
      chk("keying_pin_detach", k[4] ? 32'h1 << k[3:0] : 32'h0, {16'h0, keying_pin_detach});
    end
    $display("test codes done");
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd("control", 4'h0, 8'h20);
    rd("source", 4'h4, 8'h00);
    rd("car_high", 4'h8, 8'h00);
    rd("car_low", 4'hc, 8'h00);
    chk("mod_pin_oe", 32'h0, {31'h0, mod_pin_oe});
    chk("slew_limit", 32'h1, {31'h0, slew_limit});
    chk("keying_pin_detach", 32'h0, {16'h0, keying_pin_detach});
    pin(1'b0);
    $display("test reset again done");
    stop_test;
  end
endmodule
bind dsm_signal_modulator dsm_checker u_chk (.clk, .reset, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .mod_pin_out, .mod_pin_oe,
  .slew_limit, .keying_pin_detach, .carrier_pin_detach);
`default_nettype wire
